// ---- verilog/fps_map.svh ----
`ifndef FPS_MAP_SVH
`define FPS_MAP_SVH

// ----------------------------------------------------------------
// Clock and program/erase timing
// ----------------------------------------------------------------
`define FPS_CLK_HZ 100_000_000
`define FPS_CLK_NS 10
`define FPS_ERASE_NS 400_000_000
`define FPS_PROG_NS 1_000_000
`define FPS_TIMER_TICKS 512
`define FPS_TIMER_EXTRA 2
`define FPS_ERASE_CNT (((`FPS_ERASE_NS / `FPS_CLK_NS) - `FPS_TIMER_EXTRA + `FPS_TIMER_TICKS - 1) / `FPS_TIMER_TICKS)
`define FPS_PROG_CNT (((`FPS_PROG_NS / `FPS_CLK_NS) - `FPS_TIMER_EXTRA + `FPS_TIMER_TICKS - 1) / `FPS_TIMER_TICKS)
`define FPS_PGM_CLK_HZ 66_000
`define FPS_CLK_DIV (`FPS_CLK_HZ / `FPS_PGM_CLK_HZ)
`define FPS_WAIT_DEF 16'hC004

// ----------------------------------------------------------------
// Flash controller map
// ----------------------------------------------------------------
`define FPS_DEV_CTRL 32'h8010_2000
`define FPS_DEV_TIMER 32'h8010_2008
`define FPS_DEV_WAIT 32'h8010_2010
`define FPS_DEV_CLKDIV 32'h8010_201C
`define FPS_CTRL_IDLE 32'h0000_0005
`define FPS_CTRL_PROT_TRIG 32'h0000_4087
`define FPS_CTRL_ERASE_TRIG 32'h0000_8081
`define FPS_CTRL_MARK_TRIG 32'h0000_4085
`define FPS_CTRL_PROG_TRIG 32'h0000_8083
`define FPS_CTRL_PRESET 32'h0000_0400
`define FPS_CTRL_READBACK 32'h0000_0020
`define FPS_CTRL_LOAD 32'h0000_4000
`define FPS_TIMER_EN 32'h8000_0000
`define FPS_TIMER_MASK 32'h00FF_FFFF
`define FPS_REGION_MASK 32'hFFFF_0000
`define FPS_SMALL_REGION 32'h104F_0000
`define FPS_SMALL_MASK 32'hFFFF_E000
`define FPS_LARGE_MASK 32'hFFFF_0000
`define FPS_UNPROT_VAL 32'h0000_0000
`define FPS_PROT_VAL 32'h0000_0001

// ----------------------------------------------------------------
// Own register map
// ----------------------------------------------------------------
`define FPS_REG_CMD 8'h00
`define FPS_REG_ADDR 8'h04
`define FPS_REG_DATA 8'h08
`define FPS_REG_ETIME 8'h0C
`define FPS_REG_PTIME 8'h10
`define FPS_REG_CFG 8'h14
`define FPS_REG_STAT 8'h18
`define FPS_REG_RDATA 8'h1C
`define FPS_STAT_BUSY 0
`define FPS_STAT_DONE 1
`define FPS_OP_COUNT 4'hB

`endif

// ---- verilog/fps_pkg.sv ----
package fps_pkg;

  typedef enum logic [3:0] {
    FPS_OP_INIT,
    FPS_OP_UNPROT,
    FPS_OP_PROT,
    FPS_OP_ERASE,
    FPS_OP_MARK,
    FPS_OP_PRESET,
    FPS_OP_WRITE,
    FPS_OP_LOAD,
    FPS_OP_PROGRAM,
    FPS_OP_READ,
    FPS_OP_READ_LATCH
  } fps_op_t;

  typedef enum logic [1:0] {
    FPS_SK_WRITE,
    FPS_SK_READ,
    FPS_SK_POLL
  } fps_kind_t;

  typedef struct packed {
    logic valid;
    fps_kind_t kind;
    logic [31:0] addr;
    logic [31:0] data;
  } fps_step_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } fps_apb_req_t;

  typedef enum logic [1:0] {
    FPS_MS_IDLE,
    FPS_MS_SETUP,
    FPS_MS_ACCESS
  } fps_mstate_t;

endpackage

// ---- verilog/fps_sequencer.sv ----
`timescale 1ns/1ps
`include "fps_map.svh"

module fps_sequencer (
  input wire logic clk, // 100 MHz clock
  input wire logic arst_n, // Async reset
  input wire logic s_psel, // Slave select
  input wire logic s_penable, // Slave enable
  input wire logic s_pwrite, // Slave direction
  input wire logic [7:0] s_paddr, // Slave byte address
  input wire logic [31:0] s_pwdata, // Slave write data
  output logic [31:0] s_prdata, // Slave read data
  output logic s_pready, // Slave ready
  output logic s_pslverr, // Slave error
  output fps_pkg::fps_apb_req_t m_req, // Master request
  input wire logic [31:0] m_prdata, // Master read data
  input wire logic m_pready // Master ready
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fps_pkg::fps_op_t op_q;
  fps_pkg::fps_mstate_t st;
  logic [2:0] step_q;
  logic [31:0] addr_q;
  logic [31:0] data_q;
  logic [31:0] etime_q;
  logic [31:0] ptime_q;
  logic [31:0] cfg_q;
  logic [31:0] rdata_q;
  logic busy;
  logic done;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // ----------------------------------------------------------------
  // Step table
  // ----------------------------------------------------------------
  function automatic fps_pkg::fps_step_t mk(input fps_pkg::fps_kind_t k,
                                            input logic [31:0] a, input logic [31:0] d);
    fps_pkg::fps_step_t s;
    s.valid = 1'b1;
    s.kind = k;
    s.addr = a;
    s.data = d;
    return s;
  endfunction

  function automatic logic [31:0] base_of(input logic [31:0] a);
    logic [31:0] r;
    r = ((a & `FPS_REGION_MASK) == `FPS_SMALL_REGION) ? (a & `FPS_SMALL_MASK)
                                                      : (a & `FPS_LARGE_MASK);
    return r;
  endfunction

  function automatic fps_pkg::fps_step_t step_of(
    input fps_pkg::fps_op_t op, input logic [2:0] i, input logic [31:0] a,
    input logic [31:0] d, input logic [31:0] et, input logic [31:0] pt,
    input logic [31:0] cfg);
    fps_pkg::fps_step_t s;
    logic [31:0] w;
    logic [31:0] c;
    logic [31:0] b;
    s = '0;
    w = fps_pkg::FPS_SK_WRITE == fps_pkg::FPS_SK_WRITE ? `FPS_CTRL_IDLE : '0;
    c = `FPS_DEV_CTRL;
    b = base_of(a);
    unique case (op)
      fps_pkg::FPS_OP_INIT:
        unique case (i)
          3'h0: s = mk(fps_pkg::FPS_SK_WRITE, `FPS_DEV_CLKDIV, {16'h0000, cfg[15:0]});
          3'h1: s = mk(fps_pkg::FPS_SK_WRITE, `FPS_DEV_WAIT, {16'h0000, cfg[31:16]});
          default: s = '0;
        endcase
      fps_pkg::FPS_OP_UNPROT, fps_pkg::FPS_OP_PROT:
        unique case (i)
          3'h0: s = mk(fps_pkg::FPS_SK_WRITE, b, (op == fps_pkg::FPS_OP_PROT) ?
                       `FPS_PROT_VAL : `FPS_UNPROT_VAL);
          3'h1: s = mk(fps_pkg::FPS_SK_WRITE, c, `FPS_CTRL_PROT_TRIG);
          3'h2: s = mk(fps_pkg::FPS_SK_WRITE, c, w);
          default: s = '0;
        endcase
      fps_pkg::FPS_OP_ERASE, fps_pkg::FPS_OP_PROGRAM:
        unique case (i)
          3'h0: s = mk(fps_pkg::FPS_SK_WRITE, `FPS_DEV_TIMER, `FPS_TIMER_EN |
                       (((op == fps_pkg::FPS_OP_ERASE) ? et : pt) & `FPS_TIMER_MASK));
          3'h1: s = (op == fps_pkg::FPS_OP_ERASE) ? mk(fps_pkg::FPS_SK_WRITE, a, d)
                  : mk(fps_pkg::FPS_SK_WRITE, c, `FPS_CTRL_PROG_TRIG);
          3'h2: s = (op == fps_pkg::FPS_OP_ERASE) ?
                  mk(fps_pkg::FPS_SK_WRITE, c, `FPS_CTRL_ERASE_TRIG)
                  : mk(fps_pkg::FPS_SK_POLL, `FPS_DEV_TIMER, '0);
          3'h3: s = (op == fps_pkg::FPS_OP_ERASE) ? mk(fps_pkg::FPS_SK_POLL, `FPS_DEV_TIMER, '0)
                  : mk(fps_pkg::FPS_SK_WRITE, c, w);
          3'h4: s = (op == fps_pkg::FPS_OP_ERASE) ? mk(fps_pkg::FPS_SK_WRITE, c, w) : '0;
          default: s = '0;
        endcase
      fps_pkg::FPS_OP_MARK:
        unique case (i)
          3'h0: s = mk(fps_pkg::FPS_SK_WRITE, a, d);
          3'h1: s = mk(fps_pkg::FPS_SK_WRITE, c, `FPS_CTRL_MARK_TRIG);
          3'h2: s = mk(fps_pkg::FPS_SK_WRITE, c, w);
          default: s = '0;
        endcase
      fps_pkg::FPS_OP_PRESET:
        unique case (i)
          3'h0: s = mk(fps_pkg::FPS_SK_WRITE, c, w | `FPS_CTRL_PRESET);
          3'h1: s = mk(fps_pkg::FPS_SK_WRITE, c, w);
          default: s = '0;
        endcase
      fps_pkg::FPS_OP_WRITE:
        s = (i == 3'h0) ? mk(fps_pkg::FPS_SK_WRITE, a, d) : '0;
      fps_pkg::FPS_OP_LOAD:
        unique case (i)
          3'h0: s = mk(fps_pkg::FPS_SK_WRITE, c, w | `FPS_CTRL_LOAD);
          3'h1: s = mk(fps_pkg::FPS_SK_WRITE, c, w);
          default: s = '0;
        endcase
      fps_pkg::FPS_OP_READ:
        s = (i == 3'h0) ? mk(fps_pkg::FPS_SK_READ, a, '0) : '0;
      fps_pkg::FPS_OP_READ_LATCH:
        unique case (i)
          3'h0: s = mk(fps_pkg::FPS_SK_WRITE, c, w | `FPS_CTRL_READBACK);
          3'h1: s = mk(fps_pkg::FPS_SK_READ, a, '0);
          3'h2: s = mk(fps_pkg::FPS_SK_WRITE, c, w);
          default: s = '0;
        endcase
    endcase
    return s;
  endfunction

  function automatic fps_pkg::fps_apb_req_t to_req(input fps_pkg::fps_step_t s);
    fps_pkg::fps_apb_req_t r;
    r.psel = 1'b1;
    r.penable = 1'b0;
    r.pwrite = (s.kind == fps_pkg::FPS_SK_WRITE);
    r.paddr = s.addr;
    r.pwdata = s.data;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Slave decode
  // ----------------------------------------------------------------
  wire s_acc = s_psel && s_penable && !s_pready;
  wire s_wr = s_acc && s_pwrite;
  wire hit_cmd = (s_paddr == `FPS_REG_CMD);
  wire hit_addr = (s_paddr == `FPS_REG_ADDR);
  wire hit_data = (s_paddr == `FPS_REG_DATA);
  wire hit_etime = (s_paddr == `FPS_REG_ETIME);
  wire hit_ptime = (s_paddr == `FPS_REG_PTIME);
  wire hit_cfg = (s_paddr == `FPS_REG_CFG);
  wire hit_stat = (s_paddr == `FPS_REG_STAT);
  wire hit_rdata = (s_paddr == `FPS_REG_RDATA);
  wire hit_any = hit_cmd | hit_addr | hit_data | hit_etime | hit_ptime | hit_cfg |
                 hit_stat | hit_rdata;
  wire op_ok = (s_pwdata[3:0] < `FPS_OP_COUNT);
  wire cmd_go = s_wr && hit_cmd && !busy && op_ok;
  wire done_clr = s_wr && hit_stat && s_pwdata[`FPS_STAT_DONE];
  wire fps_pkg::fps_op_t cmd_op = fps_pkg::fps_op_t'(s_pwdata[3:0]);
  wire [31:0] rd_mux = hit_cmd ? {28'h000_0000, op_q} :
                       hit_addr ? addr_q : hit_data ? data_q :
                       hit_etime ? etime_q : hit_ptime ? ptime_q :
                       hit_cfg ? cfg_q : hit_rdata ? rdata_q :
                       hit_stat ? {30'h0000_0000, done, busy} : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Sequencer decode
  // ----------------------------------------------------------------
  wire fps_pkg::fps_step_t step_first = step_of(cmd_op, 3'h0, addr_q, data_q, etime_q,
                                                ptime_q, cfg_q);
  wire fps_pkg::fps_step_t step_cur = step_of(op_q, step_q, addr_q, data_q, etime_q,
                                              ptime_q, cfg_q);
  wire fps_pkg::fps_step_t step_nxt = step_of(op_q, step_q + 3'h1, addr_q, data_q,
                                              etime_q, ptime_q, cfg_q);
  wire xfer_done = (st == fps_pkg::FPS_MS_ACCESS) && m_pready;
  wire poll_again = (step_cur.kind == fps_pkg::FPS_SK_POLL) &&
                    ((m_prdata & `FPS_TIMER_MASK) != 32'h0000_0000);
  wire op_end = xfer_done && !poll_again && !step_nxt.valid;

  // ----------------------------------------------------------------
  // Slave registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_pready <= 1'b0;
      s_pslverr <= 1'b0;
      s_prdata <= '0;
    end
    else
    begin
      s_pready <= s_acc;
      s_pslverr <= s_acc && !hit_any;
      s_prdata <= (s_acc && !s_pwrite) ? rd_mux : '0;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      addr_q <= '0;
      data_q <= '0;
      etime_q <= 32'(`FPS_ERASE_CNT);
      ptime_q <= 32'(`FPS_PROG_CNT);
      cfg_q <= {`FPS_WAIT_DEF, 16'(`FPS_CLK_DIV)};
    end
    else if (s_wr && !busy)
    begin
      if (hit_addr) addr_q <= s_pwdata;
      if (hit_data) data_q <= s_pwdata;
      if (hit_etime) etime_q <= s_pwdata;
      if (hit_ptime) ptime_q <= s_pwdata;
      if (hit_cfg) cfg_q <= s_pwdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n) done <= 1'b0;
    else done <= op_end || (done && !done_clr);
  end

  // ----------------------------------------------------------------
  // Master sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= fps_pkg::FPS_MS_IDLE;
      op_q <= fps_pkg::FPS_OP_INIT;
      step_q <= '0;
      busy <= 1'b0;
      m_req <= '0;
    end
    else
    begin
      unique case (st)
        fps_pkg::FPS_MS_IDLE:
          if (cmd_go)
          begin
            op_q <= cmd_op;
            step_q <= '0;
            busy <= 1'b1;
            m_req <= to_req(step_first);
            st <= fps_pkg::FPS_MS_SETUP;
          end
        fps_pkg::FPS_MS_SETUP:
        begin
          m_req.penable <= 1'b1;
          st <= fps_pkg::FPS_MS_ACCESS;
        end
        fps_pkg::FPS_MS_ACCESS:
          if (m_pready)
          begin
            if (poll_again)
            begin
              m_req <= to_req(step_cur);
              st <= fps_pkg::FPS_MS_SETUP;
            end
            else if (step_nxt.valid)
            begin
              step_q <= step_q + 3'h1;
              m_req <= to_req(step_nxt);
              st <= fps_pkg::FPS_MS_SETUP;
            end
            else
            begin
              busy <= 1'b0;
              m_req <= '0;
              st <= fps_pkg::FPS_MS_IDLE;
            end
          end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n) rdata_q <= '0;
    else if (xfer_done && step_cur.kind == fps_pkg::FPS_SK_READ) rdata_q <= m_prdata;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [31:0] prev_wdata;
  logic armed;
  wire wr_done = xfer_done && m_req.pwrite;
  wire ctrl_done = wr_done && (m_req.paddr == `FPS_DEV_CTRL);
  wire trig_done = ctrl_done && ((m_req.pwdata == `FPS_CTRL_ERASE_TRIG) ||
                                 (m_req.pwdata == `FPS_CTRL_PROG_TRIG));

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prev_wdata <= '0;
      armed <= 1'b0;
    end
    else
    begin
      if (wr_done) prev_wdata <= m_req.pwdata;
      if (wr_done && m_req.paddr == `FPS_DEV_TIMER) armed <= 1'b1;
      else if (trig_done) armed <= 1'b0;
    end
  end

  sequence seq_setup;
    m_req.psel && !m_req.penable;
  endsequence

  sequence seq_access;
    m_req.psel && m_req.penable;
  endsequence

  AST_SETUP_THEN_ACCESS: assert property (seq_setup |=> (seq_access and
    ($stable(m_req.paddr) && $stable(m_req.pwdata))))
    else $error("setup not followed by held access");

  AST_HOLD_WHILE_WAIT: assert property (seq_access ##0 !m_pready |=> (seq_access and
    $stable(m_req)))
    else $error("request changed during wait");

  AST_POLL_REPEATS: assert property (xfer_done && poll_again |=> (seq_setup and
    (m_req.paddr == `FPS_DEV_TIMER && !m_req.pwrite)))
    else $error("busy timer not polled again");

  AST_UNPROT_EVEN: assert property (ctrl_done && m_req.pwdata == `FPS_CTRL_PROT_TRIG &&
    op_q == fps_pkg::FPS_OP_UNPROT |-> !prev_wdata[0])
    else $error("unprotect trigger without even value");

  AST_PROT_ODD: assert property (ctrl_done && m_req.pwdata == `FPS_CTRL_PROT_TRIG &&
    op_q == fps_pkg::FPS_OP_PROT |-> prev_wdata[0])
    else $error("protect trigger without odd value");

  AST_TIMER_ARMED: assert property (trig_done |-> armed)
    else $error("erase or program trigger with timer not armed");

  AST_ONE_SHOT: assert property (op_end && op_q inside {fps_pkg::FPS_OP_ERASE,
    fps_pkg::FPS_OP_PROGRAM, fps_pkg::FPS_OP_MARK, fps_pkg::FPS_OP_LOAD}
    |-> m_req.pwdata == `FPS_CTRL_IDLE)
    else $error("request bits left set at end");

  AST_SECTOR_BASE: assert property (seq_setup && step_q == 3'h0 && (op_q ==
    fps_pkg::FPS_OP_UNPROT || op_q == fps_pkg::FPS_OP_PROT) |-> m_req.paddr ==
    base_of(m_req.paddr))
    else $error("protect value not at sector base");

  AST_SLAVE_ONE_WAIT: assert property (s_psel && s_penable && !s_pready |=> s_pready ##1
    !s_pready)
    else $error("slave ready timing wrong");

  AST_DONE_STICKY: assert property (op_end |=> done ##1 (done || $past(done_clr)))
    else $error("done flag not held");

endmodule // fps_sequencer

// ---- verification/fps_dev_model.sv ----
`timescale 1ns/1ps
module fps_dev_model (
  input wire logic clk, // Bus clock
  input wire logic arst_n, // Async reset
  input wire logic slow, // Longer answer delay
  input wire fps_pkg::fps_apb_req_t req, // Request from sequencer
  output logic [31:0] prdata, // Read data
  output logic pready // Ready
);
  logic [31:0] ctrl, tmr, wst, cdiv, last_waddr, last_wdata, last_trig, tmr_load, last_rd;
  logic [31:0] rval;
  logic [31:0] wbuf [4];
  logic [31:0] lat [4];
  logic [31:0] mem [256];
  logic [2:0] cnt;
  wire acc = req.psel & req.penable;
  wire is_flash = req.paddr[31:20] == 12'h104;
  wire wr_ok = acc & pready & req.pwrite;
  wire busy = tmr[23:0] != 24'h00_0000;
  // Timer counts only once enabled and started by the erase/program request bit (ctrl bit 15)
  wire run_t = busy & tmr[31] & ctrl[15];
  wire stall = run_t & (is_flash & ~req.pwrite | req.paddr == 32'h8010_2000 & req.pwrite);
  wire ans = acc & ~stall & (cnt >= (slow ? 3'h3 : 3'h1));
  assign pready = ans;
  // Released bus shows the inverse of the last answer
  assign prdata = ans ? rval : ~last_rd;
  always_comb
  begin
    rval = 32'hFFFF_FFFF;
    if (is_flash)
      rval = ctrl[5] ? lat[req.paddr[3:2]] : mem[req.paddr[9:2]];
    else if (req.paddr == 32'h8010_2000)
      rval = ctrl;
    else if (req.paddr == 32'h8010_2008)
      rval = tmr;
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl <= 32'h0000_0005;
      {tmr, wst, cdiv, last_waddr, last_wdata, last_trig, tmr_load, last_rd} <= '0;
      cnt <= 3'h0;
      for (int k = 0; k < 256; k++)
        mem[k] <= 32'hFFFF_FFFF;
      for (int k = 0; k < 4; k++)
      begin
        lat[k] <= 32'hFFFF_FFFF;
        wbuf[k] <= 32'hFFFF_FFFF;
      end
    end
    else
    begin
      cnt <= (acc & ~ans & cnt != 3'h7) ? cnt + 3'h1 : 3'h0;
      if (run_t)
        tmr <= tmr - 32'h0000_0001;
      if (ans)
        last_rd <= rval;
      if (wr_ok & is_flash)
      begin
        wbuf[req.paddr[3:2]] <= req.pwdata;
        last_waddr <= req.paddr;
        last_wdata <= req.pwdata;
        if (req.paddr[3:0] == 4'hC)
          for (int k = 0; k < 4; k++)
            lat[k] <= (k == 3) ? req.pwdata : wbuf[k];
      end
      if (wr_ok & req.paddr == 32'h8010_2008)
      begin
        tmr <= req.pwdata;
        tmr_load <= req.pwdata;
      end
      if (wr_ok & req.paddr == 32'h8010_2010)
        wst <= req.pwdata;
      if (wr_ok & req.paddr == 32'h8010_201C)
        cdiv <= req.pwdata;
      if (wr_ok & req.paddr == 32'h8010_2000)
      begin
        ctrl <= req.pwdata;
        if (req.pwdata != 32'h0000_0005)
          last_trig <= req.pwdata;
        for (int k = 0; k < 4; k++)
        begin
          if (req.pwdata == 32'h0000_4005)
            lat[k] <= wbuf[k];
          if (ctrl[10] & ~req.pwdata[10])
            lat[k] <= 32'hFFFF_FFFF;
          if (req.pwdata == 32'h0000_8083)
            mem[{last_waddr[9:4], k[1:0]}] <= lat[k];
        end
      end
    end
  end
endmodule // fps_dev_model

// ---- verification/fps_sequencer_bench.sv ----
`timescale 1ns/1ps
`include "fps_map.svh"
module fps_sequencer_bench;
  logic clk, arst_n, psel, penable, pwrite, slow;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd, rnd;
  logic [31:0] dw [4];
  logic [33:0] ex;
  logic [33:0] exp_q [$];
  wire logic [31:0] s_prdata, m_prdata;
  wire logic s_pready, s_pslverr, m_pready;
  fps_pkg::fps_apb_req_t m_req;
  int err_count, tests_run;
  fps_sequencer dut_u (.clk(clk), .arst_n(arst_n), .s_psel(psel), .s_penable(penable),
    .s_pwrite(pwrite), .s_paddr(paddr), .s_pwdata(pwdata), .s_prdata(s_prdata),
    .s_pready(s_pready), .s_pslverr(s_pslverr), .m_req(m_req), .m_prdata(m_prdata),
    .m_pready(m_pready));
  fps_dev_model m_u (.clk(clk), .arst_n(arst_n), .slow(slow), .req(m_req),
    .prdata(m_prdata), .pready(m_pready));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [33:0] e);
    int n;
    exp_q.push_back(e);
    rnd = xs(rnd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    slow <= rnd[0];
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (s_pready !== 1'b1 && n < 100);
    rd = s_prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 100)
    begin
      err_count++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 34'h0_0000_0000);
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, {2'b10, e});
  endtask
  task automatic run(input logic [3:0] op);
    int n;
    wr(`FPS_REG_CMD, {28'h000_0000, op});
    n = 0;
    do
    begin
      apb(1'b0, `FPS_REG_STAT, 32'h0000_0000, 34'h0_0000_0000);
      n++;
    end
    while (rd[1] !== 1'b1 && n < 300);
    if (rd[1] !== 1'b1)
    begin
      err_count++;
      tally_and_finish();
    end
    cmp("stat", 32'h0000_0002, rd);
    wr(`FPS_REG_STAT, 32'h0000_0002);
  endtask
  // ----------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------
  always @(posedge clk)
    if (s_pready === 1'b1)
    begin
      ex = exp_q.size() > 0 ? exp_q.pop_front() : 34'h3_FFFF_FFFF;
      cmp("pslverr", {31'h0, ex[32]}, {31'h0, s_pslverr});
      if (ex[33])
        cmp("prdata", ex[31:0], s_prdata);
    end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {arst_n, psel, penable, pwrite, slow, paddr, pwdata, rd} = '0;
    rnd = 32'd67247;
    err_count = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rdx(`FPS_REG_ETIME, 32'd78125);
    rdx(`FPS_REG_PTIME, 32'd196);
    rdx(`FPS_REG_CFG, 32'hC004_05EB);
    apb(1'b0, 8'h20, 32'h0000_0000, {2'b11, 32'h0000_0000});
    wr(`FPS_REG_CMD, 32'h0000_000C);
    rdx(`FPS_REG_STAT, 32'h0000_0000);
    $display("test reset_and_refusal done");
    run(4'h0);
    cmp("clkdiv", 32'h0000_05EB, m_u.cdiv);
    cmp("wait", 32'h0000_C004, m_u.wst);
    wr(`FPS_REG_ADDR, 32'h104F_3004);
    run(4'h1);
    cmp("base", 32'h104F_2000, m_u.last_waddr);
    cmp("even", 32'h0000_0000, m_u.last_wdata);
    cmp("trig", 32'h0000_4087, m_u.last_trig);
    wr(`FPS_REG_ADDR, 32'h1043_1234);
    run(4'h2);
    cmp("base", 32'h1043_0000, m_u.last_waddr);
    cmp("odd", 32'h0000_0001, m_u.last_wdata);
    cmp("trig", 32'h0000_4087, m_u.last_trig);
    $display("test protection done");
    wr(`FPS_REG_ETIME, 32'h0000_0005);
    wr(`FPS_REG_ADDR, 32'h1043_0010);
    wr(`FPS_REG_DATA, rnd);
    run(4'h3);
    cmp("tload", 32'h8000_0005, m_u.tmr_load);
    cmp("trig", 32'h0000_8081, m_u.last_trig);
    cmp("ctrl", 32'h0000_0005, m_u.ctrl);
    wr(`FPS_REG_ADDR, 32'h1044_0000);
    run(4'h4);
    cmp("trig", 32'h0000_4085, m_u.last_trig);
    $display("test erase done");
    run(4'h5);
    cmp("preset", 32'hFFFF_FFFF, m_u.lat[1]);
    for (int i = 0; i < 4; i++)
    begin
      dw[i] = rnd;
      wr(`FPS_REG_ADDR, 32'h1040_0200 + 32'(4 * i));
      wr(`FPS_REG_DATA, dw[i]);
      run(4'h6);
      if (i == 2)
        cmp("early", 32'hFFFF_FFFF, m_u.lat[2]);
    end
    for (int i = 0; i < 4; i++)
      cmp("latch", dw[i], m_u.lat[i]);
    wr(`FPS_REG_ADDR, 32'h1040_0208);
    run(4'hA);
    rdx(`FPS_REG_RDATA, dw[2]);
    cmp("ctrl", 32'h0000_0005, m_u.ctrl);
    $display("test latch done");
    wr(`FPS_REG_PTIME, 32'h0000_0003);
    run(4'h8);
    cmp("tload", 32'h8000_0003, m_u.tmr_load);
    cmp("trig", 32'h0000_8083, m_u.last_trig);
    cmp("ctrl", 32'h0000_0005, m_u.ctrl);
    wr(`FPS_REG_ADDR, 32'h1040_0204);
    run(4'h9);
    rdx(`FPS_REG_RDATA, dw[1]);
    wr(`FPS_REG_ADDR, 32'h1040_0214);
    run(4'h9);
    rdx(`FPS_REG_RDATA, 32'hFFFF_FFFF);
    wr(`FPS_REG_ADDR, 32'h1040_0300);
    wr(`FPS_REG_DATA, ~dw[3]);
    run(4'h6);
    run(4'h7);
    cmp("load", ~dw[3], m_u.lat[0]);
    run(4'h5);
    cmp("preset", 32'hFFFF_FFFF, m_u.lat[0]);
    $display("test program done");
    tally_and_finish();
  end
endmodule // fps_sequencer_bench
